/* logic/sim_motor_pkg.sv */
/*
 * Shared constants and types of the virtual motor simulation block.
 * Assumes a 100 MHz system clock and a plain strobe register port.
 */
package sim_motor_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MODE_SET = 8'h00;
    localparam logic [7:0] OFS_MODE_ACT = 8'h04;
    localparam logic [7:0] OFS_COORD_CFG = 8'h08;
    localparam logic [7:0] OFS_USER_RANGE = 8'h0c;
    localparam logic [7:0] OFS_USER_OFFSET = 8'h10;
    localparam logic [7:0] OFS_USER_ZERO = 8'h14;
    localparam logic [7:0] OFS_CMD_POS = 8'h18;
    localparam logic [7:0] OFS_FB_POS = 8'h1c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int COORD_SRC_BIT = 0;
    localparam int MECH_BIT = 1;
    localparam int USER_WRAP_EN_BIT = 16;

    // ------------------------------------------------------------
    // Simulation mode codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_REAL = 2'h0,
        MODE_VIRT_NO_INFO = 2'h1,
        MODE_VIRT_WRAP_1800 = 2'h2,
        MODE_VIRT_WRAP_900 = 2'h3
    } sim_mode_e;

    // ------------------------------------------------------------
    // Reset values and preset coordinate figures
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [15:0] WRAP_RANGE_1800 = 16'd1800;
    localparam logic [15:0] WRAP_RANGE_900 = 16'd900;
    localparam logic [7:0] PRESET_OFFSET_RATIO = 8'd50;
    localparam logic [15:0] PRESET_OFFSET_VALUE = 16'h0000;
    localparam logic [15:0] USER_RANGE_RESET = 16'd1;
    localparam logic [7:0] USER_RATIO_RESET = 8'd50;
    localparam logic [15:0] USER_ZERO_RESET = 16'd1;

    // ------------------------------------------------------------
    // Indicator timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int LED_PHASE_MS = 500;
    localparam int LED_PHASE_CYCLES = CLK_HZ / 1000 * LED_PHASE_MS;

    // Coordinate and wrap setup handed to the position logic
    typedef struct packed {
        logic [15:0] wrap_range;
        logic [7:0] offset_ratio;
        logic [15:0] offset_value;
        logic wrap_en;
        logic [15:0] wrap_zero_count;
        logic from_sensor;
    } coord_cfg_s;

endpackage

/* logic/virtual_motor_simulation.sv */
/*
 * Virtual motor simulation logic of a servo driver: mode latching at
 * power-on, coordinate setup selection, virtual positions, output
 * gating of excitation, brake and sensor home writes, and indicator.
 * Assumes all inputs synchronous to clk_sys_in; power_on_in is a
 * one-cycle pulse when control power has come on.
 */
module virtual_motor_simulation
    import sim_motor_pkg::*;
#(
    parameter int LED_PHASE = LED_PHASE_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Power and motor presence
    input wire logic power_on_in,
    input wire logic motor_present_in,
    input wire logic alarm_in,
    // Motion from the operation engine
    input wire logic step_in,
    input wire logic step_dir_in,
    input wire logic home_set_in,
    input wire logic [31:0] sensor_pos_in,
    // Requests toward the power stage and sensor
    input wire logic excite_req_in,
    input wire logic brake_release_req_in,
    input wire logic sensor_home_wr_req_in,
    output logic excite_out,
    output logic brake_release_out,
    output logic sensor_home_wr_out,
    // Coordinate setup held by the absolute sensor
    input wire coord_cfg_s sensor_cfg_in,
    output coord_cfg_s coord_cfg_out,
    // Status
    output logic sim_active_out,
    output logic [31:0] cmd_pos_out,
    output logic [31:0] fb_pos_out,
    output logic power_alarm_indicator_green_out,
    output logic power_alarm_indicator_red_out
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    sim_mode_e mode_set_r;
    sim_mode_e mode_act_r;
    logic coord_src_r;
    logic mech_r;
    logic [15:0] user_range_r;
    logic [7:0] user_ratio_r;
    logic [15:0] user_offset_r;
    logic user_wrap_en_r;
    logic [15:0] user_zero_r;
    logic [31:0] home_ofs_r;
    logic [31:0] cmd_abs_r;
    logic [31:0] fb_virt_r;
    coord_cfg_s cfg_r;
    coord_cfg_s cfg_nxt;
    coord_cfg_s user_cfg;
    logic sim_on;
    logic [31:0] fb_abs;

    typedef enum logic [1:0] {
        LED_GREEN,
        LED_RED,
        LED_BOTH,
        LED_DARK
    } led_phase_e;
    led_phase_e led_r;
    logic [25:0] led_cnt_r;
    logic led_tick;

    assign sim_on = (mode_act_r != MODE_REAL);
    assign sim_active_out = sim_on;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            mode_set_r <= sim_mode_e'(MODE_RESET);
        end else if (reg_wr_in && reg_addr_in == OFS_MODE_SET) begin
            mode_set_r <= sim_mode_e'(reg_wdata_in[1:0]);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            coord_src_r <= 1'b0;
            mech_r <= 1'b0;
            user_range_r <= USER_RANGE_RESET;
            user_wrap_en_r <= 1'b0;
            user_ratio_r <= USER_RATIO_RESET;
            user_offset_r <= 16'h0000;
            user_zero_r <= USER_ZERO_RESET;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                OFS_COORD_CFG: begin
                    coord_src_r <= reg_wdata_in[COORD_SRC_BIT];
                    mech_r <= reg_wdata_in[MECH_BIT];
                end
                OFS_USER_RANGE: begin
                    user_range_r <= reg_wdata_in[15:0];
                    user_wrap_en_r <= reg_wdata_in[USER_WRAP_EN_BIT];
                end
                OFS_USER_OFFSET: begin
                    user_offset_r <= reg_wdata_in[15:0];
                    user_ratio_r <= reg_wdata_in[23:16];
                end
                OFS_USER_ZERO: begin
                    user_zero_r <= reg_wdata_in[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode takes effect only at power-on
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            mode_act_r <= MODE_REAL;
        end else if (power_on_in) begin
            mode_act_r <= mode_set_r;
        end
    end

    // ------------------------------------------------------------
    // Coordinate setup selection
    // ------------------------------------------------------------
    always_comb begin
        user_cfg.wrap_range = user_range_r;
        user_cfg.offset_ratio = user_ratio_r;
        user_cfg.offset_value = user_offset_r;
        user_cfg.wrap_en = user_wrap_en_r;
        user_cfg.wrap_zero_count = user_zero_r;
        user_cfg.from_sensor = 1'b0;
    end

    always_comb begin
        cfg_nxt = user_cfg;
        if (motor_present_in) begin
            if (!mech_r) begin
                cfg_nxt = sensor_cfg_in;
                cfg_nxt.from_sensor = 1'b1;
            end
        end else if (!coord_src_r) begin
            case (mode_set_r)
                MODE_VIRT_WRAP_1800: begin
                    cfg_nxt.wrap_range = WRAP_RANGE_1800;
                    cfg_nxt.offset_ratio = PRESET_OFFSET_RATIO;
                    cfg_nxt.offset_value = PRESET_OFFSET_VALUE;
                    cfg_nxt.wrap_en = 1'b1;
                    cfg_nxt.wrap_zero_count = WRAP_RANGE_1800;
                end
                MODE_VIRT_WRAP_900: begin
                    cfg_nxt.wrap_range = WRAP_RANGE_900;
                    cfg_nxt.offset_ratio = PRESET_OFFSET_RATIO;
                    cfg_nxt.offset_value = PRESET_OFFSET_VALUE;
                    cfg_nxt.wrap_en = 1'b1;
                    cfg_nxt.wrap_zero_count = WRAP_RANGE_900;
                end
                default: begin
                    cfg_nxt = user_cfg;
                end
            endcase
        end
    end

    // Setup is fixed at power-on, as the initial coordinates are
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            cfg_r <= '0;
        end else if (power_on_in) begin
            cfg_r <= cfg_nxt;
        end
    end
    assign coord_cfg_out = cfg_r;

    // ------------------------------------------------------------
    // Positions and home
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            cmd_abs_r <= 32'h0000_0000;
        end else if (step_in) begin
            cmd_abs_r <= step_dir_in ? cmd_abs_r - 32'h1 : cmd_abs_r + 32'h1;
        end
    end

    // Virtual feedback tracks the command with no motor motion
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            fb_virt_r <= 32'h0000_0000;
        end else if (power_on_in) begin
            fb_virt_r <= sensor_pos_in;
        end else if (sim_on && step_in) begin
            fb_virt_r <= step_dir_in ? fb_virt_r - 32'h1 : fb_virt_r + 32'h1;
        end
    end

    assign fb_abs = sim_on ? fb_virt_r : sensor_pos_in;

    // Home held locally; the sensor copy is never touched here
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            home_ofs_r <= 32'h0000_0000;
        end else if (power_on_in) begin
            home_ofs_r <= sensor_pos_in;
        end else if (home_set_in) begin
            home_ofs_r <= fb_abs;
        end
    end

    // Command is rebased to its own count (cmd_abs_r) at power-on and home set
    logic [31:0] cmd_base_r;
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            cmd_base_r <= 32'h0000_0000;
        end else if (power_on_in || home_set_in) begin
            cmd_base_r <= cmd_abs_r;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            cmd_pos_out <= 32'h0000_0000;
            fb_pos_out <= 32'h0000_0000;
        end else begin
            cmd_pos_out <= cmd_abs_r - cmd_base_r;
            fb_pos_out <= fb_abs - home_ofs_r;
        end
    end

    // ------------------------------------------------------------
    // Output gating toward power stage, brake and sensor
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            excite_out <= 1'b0;
            brake_release_out <= 1'b0;
            sensor_home_wr_out <= 1'b0;
        end else begin
            excite_out <= excite_req_in && !sim_on;
            brake_release_out <= brake_release_req_in && !sim_on;
            sensor_home_wr_out <= sensor_home_wr_req_in && !sim_on;
        end
    end

    // ------------------------------------------------------------
    // Indicator
    // ------------------------------------------------------------
    assign led_tick = (led_cnt_r == 26'(LED_PHASE - 1));

    always_ff @(posedge clk_sys_in) begin
        if (reset_in || !sim_on || led_tick) begin
            led_cnt_r <= 26'h0;
        end else begin
            led_cnt_r <= led_cnt_r + 26'h1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in || !sim_on) begin
            led_r <= LED_GREEN;
        end else if (led_tick) begin
            case (led_r)
                LED_GREEN: led_r <= LED_RED;
                LED_RED: led_r <= LED_BOTH;
                LED_BOTH: led_r <= LED_DARK;
                default: led_r <= LED_GREEN;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            power_alarm_indicator_green_out <= 1'b0;
            power_alarm_indicator_red_out <= 1'b0;
        end else if (sim_on) begin
            power_alarm_indicator_green_out <= (led_r == LED_GREEN) || (led_r == LED_BOTH);
            power_alarm_indicator_red_out <= (led_r == LED_RED) || (led_r == LED_BOTH);
        end else begin
            power_alarm_indicator_green_out <= !alarm_in;
            power_alarm_indicator_red_out <= alarm_in;
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                OFS_MODE_SET: reg_rdata_out <= {30'h0, mode_set_r};
                OFS_MODE_ACT: reg_rdata_out <= {30'h0, mode_act_r};
                OFS_COORD_CFG: reg_rdata_out <= {30'h0, mech_r, coord_src_r};
                OFS_USER_RANGE: reg_rdata_out <= {15'h0, user_wrap_en_r, user_range_r};
                OFS_USER_OFFSET: reg_rdata_out <= {8'h0, user_ratio_r, user_offset_r};
                OFS_USER_ZERO: reg_rdata_out <= {16'h0, user_zero_r};
                OFS_CMD_POS: reg_rdata_out <= cmd_pos_out;
                OFS_FB_POS: reg_rdata_out <= fb_pos_out;
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

endmodule

/* verification/motor_model.sv */
/*
 * Behavioural servo motor with an absolute position sensor.
 * Assumes excitation, step and home-write requests from the driver.
 */
module motor_model
    import sim_motor_pkg::*;
#(
    parameter logic [15:0] SENSOR_RANGE = 16'h012c
) (
    // Clock
    input wire logic clk_sys_in,
    // Driver requests
    input wire logic excite_in,
    input wire logic step_in,
    input wire logic step_dir_in,
    input wire logic home_wr_in,
    // Sensor side
    output logic [31:0] sensor_pos_out = 32'h00001000,
    output coord_cfg_s sensor_cfg_out,
    output logic [31:0] home_writes_out = 32'h0
);
    timeunit 1ns;
    timeprecision 100ps;
    assign sensor_cfg_out = '{SENSOR_RANGE, 8'h19, 16'h0007, 1'b0, 16'h0003, 1'b1};
    // Shaft turns only while excited; stored home counts rewrites
    always @(posedge clk_sys_in) begin
        if (excite_in && step_in) begin
            sensor_pos_out <= step_dir_in ? sensor_pos_out - 32'h1 : sensor_pos_out + 32'h1;
        end
        if (home_wr_in) begin
            home_writes_out <= home_writes_out + 32'h1;
        end
    end
endmodule

/* verification/virtual_motor_simulation_assertions.sv */
/*
 * Checker of the virtual motor simulation block.
 * Assumes binding to the top module and one clock domain.
 */
module sim_motor_chk
    import sim_motor_pkg::*;
(
    // Clock, reset, register port
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // Control inputs
    input wire logic power_on_in,
    input wire logic motor_present_in,
    input wire logic step_in,
    input wire logic step_dir_in,
    input wire logic home_set_in,
    input wire coord_cfg_s sensor_cfg_in,
    // Outputs
    input wire logic excite_out,
    input wire logic brake_release_out,
    input wire logic sensor_home_wr_out,
    input wire coord_cfg_s coord_cfg_out,
    input wire logic sim_active_out,
    input wire logic [31:0] cmd_pos_out,
    input wire logic [31:0] fb_pos_out,
    input wire logic power_alarm_indicator_green_out,
    input wire logic power_alarm_indicator_red_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    logic [1:0] set_r;
    logic [1:0] act_r;
    logic [1:0] src_r;
    logic [1:0] led;
    assign led = {power_alarm_indicator_green_out, power_alarm_indicator_red_out};
    // Shadow of mode and source settings
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            set_r <= 2'h0;
            act_r <= 2'h0;
            src_r <= 2'h0;
        end else begin
            if (reg_wr_in && reg_addr_in == OFS_MODE_SET) set_r <= reg_wdata_in[1:0];
            if (reg_wr_in && reg_addr_in == OFS_COORD_CFG) src_r <= reg_wdata_in[1:0];
            if (power_on_in) act_r <= set_r;
        end
    end
    function automatic logic preset_ok(coord_cfg_s c, logic [15:0] r);
        return c.wrap_range == r && c.offset_ratio == PRESET_OFFSET_RATIO
            && c.offset_value == PRESET_OFFSET_VALUE && c.wrap_en && c.wrap_zero_count == r;
    endfunction
    function automatic logic [1:0] led_next(logic [1:0] p);
        return p == 2'b10 ? 2'b01 : p == 2'b01 ? 2'b11 : p == 2'b11 ? 2'b00 : 2'b10;
    endfunction
    chk_no_excite: assert property (sim_active_out |=> !excite_out)
        else $error("excitation while simulating");
    chk_brake_hold: assert property (sim_active_out |=> !brake_release_out)
        else $error("brake released while simulating");
    chk_sensor_home: assert property (sim_active_out |=> !sensor_home_wr_out)
        else $error("sensor home written while simulating");
    chk_mode_latch: assert property (!power_on_in |=> $stable(sim_active_out))
        else $error("mode changed without power cycle");
    chk_wrap_1800: assert property (power_on_in && set_r == 2'h2 && !motor_present_in
        && !src_r[0] |=> preset_ok(coord_cfg_out, WRAP_RANGE_1800))
        else $error("code 2 setup wrong");
    chk_wrap_900: assert property (power_on_in && set_r == 2'h3 && !motor_present_in
        && !src_r[0] |=> preset_ok(coord_cfg_out, WRAP_RANGE_900))
        else $error("code 3 setup wrong");
    chk_sensor_setup: assert property (power_on_in && motor_present_in && !src_r[1]
        |=> coord_cfg_out.from_sensor && coord_cfg_out.wrap_range == $past(sensor_cfg_in.wrap_range))
        else $error("sensor setup not taken");
    chk_step_move: assert property (step_in && sim_active_out && !motor_present_in
        && !home_set_in && !power_on_in ##1 !home_set_in && !power_on_in
        |=> cmd_pos_out == $past(cmd_pos_out) + ($past(step_dir_in, 2) ? 32'hffffffff : 32'h1))
        else $error("command position did not follow step");
    chk_home_power: assert property (power_on_in && sim_active_out && !step_in ##1 !step_in
        |=> cmd_pos_out == 32'h0 && fb_pos_out == 32'h0)
        else $error("home not taken at power-on");
    chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data outside read slot");
    chk_led_order: assert property (sim_active_out && $past(sim_active_out, 2)
        && led != $past(led) |-> led == led_next($past(led)))
        else $error("indicator phase order wrong");
    cover property (power_on_in && act_r != 2'h0);
    cover property (step_in && sim_active_out);
    cover property (sim_active_out && led == 2'b11);
endmodule
bind virtual_motor_simulation sim_motor_chk chk_u (.*);

/* verification/testbench.sv */
/*
 * Self-checking bench of the virtual motor simulation block.
 * Assumes the design package, the motor model and the bound checker.
 */
module testbench
    import sim_motor_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PH = 4;
    localparam logic [7:0] LED_SEQ = 8'b10011100;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, power_on_in = 1'b0, motor_present_in = 1'b0;
    logic alarm_in = 1'b0, step_in = 1'b0, step_dir_in = 1'b0, home_set_in = 1'b0;
    logic excite_req_in = 1'b1, brake_release_req_in = 1'b1, sensor_home_wr_req_in = 1'b1;
    logic excite_out, brake_release_out, sensor_home_wr_out, sim_active_out, led_g, led_r;
    logic [31:0] reg_rdata_out, cmd_pos_out, fb_pos_out, sensor_pos_in, homes, pos0, exp_pos;
    logic [31:0] homes0;
    logic [31:0] rng = 32'd20003;
    logic [1:0] prev;
    coord_cfg_s sensor_cfg_in, coord_cfg_out, usr;
    logic [4:0] tbl [6] = '{5'b10000, 5'b11000, 5'b01000, 5'b10100, 5'b00001, 5'b11011};
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    virtual_motor_simulation #(.LED_PHASE(PH)) dut_u (.*,
        .power_alarm_indicator_green_out(led_g), .power_alarm_indicator_red_out(led_r));
    motor_model motor_u (.clk_sys_in(clk_sys_in), .excite_in(excite_out), .step_in(step_in),
        .step_dir_in(step_dir_in), .home_wr_in(sensor_home_wr_out),
        .sensor_pos_out(sensor_pos_in), .sensor_cfg_out(sensor_cfg_in), .home_writes_out(homes));
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic coord_cfg_s exp_cfg(logic [4:0] t, coord_cfg_s u);
        coord_cfg_s c;
        c = u;
        if (t[0] && !t[1]) begin
            c = sensor_cfg_in;
            c.from_sensor = 1'b1;
        end else if (!t[0] && !t[2] && t[4]) begin
            c = '{t[3] ? WRAP_RANGE_900 : WRAP_RANGE_1800, PRESET_OFFSET_RATIO,
                PRESET_OFFSET_VALUE, 1'b1, t[3] ? WRAP_RANGE_900 : WRAP_RANGE_1800, 1'b0};
        end
        return c;
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_sys_in);
        chk(64'(reg_rdata_out), 64'(exp), what);
    endtask
    task automatic pwr();
        @(posedge clk_sys_in);
        power_on_in <= 1'b1;
        @(posedge clk_sys_in);
        power_on_in <= 1'b0;
        repeat (2) @(negedge clk_sys_in);
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        rd(OFS_MODE_SET, 32'h0, "mode_set");
        rd(8'h40, 32'h0, "unmapped");
        wr(OFS_MODE_ACT, 32'h3);
        rd(OFS_MODE_ACT, 32'h0, "mode_act");
        chk(64'({excite_out, brake_release_out, sensor_home_wr_out}), 64'h7, "gates");
        foreach (tbl[i]) begin
            usr = coord_cfg_s'({rnd(), rnd()});
            usr.from_sensor = 1'b0;
            @(posedge clk_sys_in);
            motor_present_in <= tbl[i][0];
            wr(OFS_MODE_SET, {30'h0, tbl[i][4:3]});
            wr(OFS_COORD_CFG, {30'h0, tbl[i][1], tbl[i][2]});
            wr(OFS_USER_RANGE, {15'h0, usr.wrap_en, usr.wrap_range});
            wr(OFS_USER_OFFSET, {8'h0, usr.offset_ratio, usr.offset_value});
            wr(OFS_USER_ZERO, {16'h0, usr.wrap_zero_count});
            pwr();
            chk(64'(coord_cfg_out), 64'(exp_cfg(tbl[i], usr)), "coord_cfg");
            rd(OFS_MODE_ACT, {30'h0, tbl[i][4:3]}, "mode_act");
        end
        wr(OFS_MODE_SET, 32'h0);
        repeat (5) @(negedge clk_sys_in);
        chk(64'(sim_active_out), 64'h1, "sim_active");
        pos0 = sensor_pos_in;
        homes0 = homes;
        repeat (30) begin
            @(posedge clk_sys_in);
            {home_set_in, step_dir_in, step_in} <= 3'(rnd());
        end
        @(posedge clk_sys_in);
        {home_set_in, step_in} <= 2'h0;
        @(negedge clk_sys_in);
        chk(64'(sensor_pos_in), 64'(pos0), "shaft");
        chk(64'({excite_out, brake_release_out, sensor_home_wr_out}), 64'h0, "gates");
        chk(64'(homes), 64'(homes0), "sensor_home");
        @(posedge clk_sys_in);
        motor_present_in <= 1'b0;
        wr(OFS_MODE_SET, 32'h2);
        pwr();
        chk(64'({cmd_pos_out, fb_pos_out}), 64'h0, "home");
        exp_pos = 32'h0;
        repeat (40) begin
            @(posedge clk_sys_in);
            {step_dir_in, step_in} <= 2'(rnd());
            if (step_in) exp_pos += step_dir_in ? 32'hffffffff : 32'h1;
        end
        @(posedge clk_sys_in);
        step_in <= 1'b0;
        if (step_in) exp_pos += step_dir_in ? 32'hffffffff : 32'h1;
        rd(OFS_CMD_POS, exp_pos, "cmd_pos");
        rd(OFS_FB_POS, exp_pos, "fb_pos");
        @(posedge clk_sys_in);
        home_set_in <= 1'b1;
        @(posedge clk_sys_in);
        home_set_in <= 1'b0;
        repeat (3) @(negedge clk_sys_in);
        chk(64'({cmd_pos_out, fb_pos_out}), 64'h0, "home_set");
        do begin
            prev = {led_g, led_r};
            @(negedge clk_sys_in);
        end while (!(prev == 2'b00 && {led_g, led_r} == 2'b10));
        for (int k = 0; k < 8; k++) begin
            chk(64'({led_g, led_r}), 64'(LED_SEQ[7 - 2 * (k % 4) -: 2]), "indicator");
            repeat (PH) @(negedge clk_sys_in);
        end
        wr(OFS_MODE_SET, 32'h0);
        pwr();
        chk(64'(sim_active_out), 64'h0, "sim_active");
        finish_test();
    end
endmodule
